// [design/pbwa_bridge.sv]
// Purpose: Steers processor byte and word accesses to the 16-bit memory
//          path or the 8-bit peripheral path, with 2 or 3 states each.
// Assumes: state_en marks each state (tie high for the system clock, or
//          pulse once per subclock period); req is one cycle while idle.
// Notes: Byte data sits in the low lane of wdata/rdata; memory lanes are
//        big-endian, the even address owning bits 15:8.
`timescale 1ns/1ps
`include "pbwa_defines.svh"
module pbwa_bridge (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic state_en,
    input wire logic req,
    input wire logic req_we,
    input wire logic req_word,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic busy,
    output logic done,
    output logic [15:0] rdata,
    output logic [2:0] region,
    output logic mem_en,
    output logic mem_we,
    output logic [1:0] mem_be,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    output logic io_en,
    output logic io_we,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    output logic last
);
    // Address decode, shared by region and state count
    function automatic pbwa_pkg::pbwa_region_t decode(
        input logic [15:0] a
    );
        logic [16:0] ax;
        ax = {1'b0, a};
        if (ax >= {1'b0, `PBWA_ROM_BASE} &&
            ax < {1'b0, `PBWA_ROM_BASE} + `PBWA_ROM_BYTES)
            return pbwa_pkg::PBWA_RG_ROM;
        if (ax >= {1'b0, `PBWA_RAM_BASE} &&
            ax < {1'b0, `PBWA_RAM_BASE} + `PBWA_RAM_BYTES)
            return pbwa_pkg::PBWA_RG_RAM;
        if (ax >= {1'b0, `PBWA_IO16_BASE} &&
            ax < {1'b0, `PBWA_IO16_BASE} + `PBWA_IO16_BYTES)
            return pbwa_pkg::PBWA_RG_IO16;
        if (ax >= {1'b0, `PBWA_IO96_BASE} &&
            ax < {1'b0, `PBWA_IO96_BASE} + `PBWA_IO96_BYTES)
            return pbwa_pkg::PBWA_RG_IO96;
        return pbwa_pkg::PBWA_RG_NONE;
    endfunction

    // States per bus cycle for a region and address
    function automatic logic [1:0] states_for(
        input pbwa_pkg::pbwa_region_t r,
        input logic [15:0] a
    );
        unique case (r)
            pbwa_pkg::PBWA_RG_ROM,
            pbwa_pkg::PBWA_RG_RAM: return `PBWA_STATES_MEM;
            pbwa_pkg::PBWA_RG_IO16: return `PBWA_STATES_SLOW;
            pbwa_pkg::PBWA_RG_IO96: begin
                // Slow modules sit in one sub-window of the area
                if (a >= `PBWA_SLOW_LO && a <= `PBWA_SLOW_HI)
                    return `PBWA_STATES_SLOW;
                return `PBWA_STATES_FAST;
            end
            default: return `PBWA_STATES_MEM;
        endcase
    endfunction

    pbwa_pkg::pbwa_state_t st_q, st_d;
    pbwa_pkg::pbwa_region_t rg_q, rg_d;
    logic [1:0] cnt_q, cnt_d;
    logic [1:0] len_q, len_d;
    logic we_q, we_d;
    logic word_q, word_d;
    logic [15:0] addr_q, addr_d;
    logic [15:0] wd_q, wd_d;
    logic done_q, done_d;
    logic [15:0] rdata_q, rdata_d;
    logic mem_en_q, mem_en_d;
    logic io_en_q, io_en_d;
    logic last_q, last_d;
    logic [1:0] be_q, be_d;
    logic [7:0] io_wd_q, io_wd_d;
    logic busy_q, busy_d;
    logic mem_we_q, mem_we_d;
    logic io_we_q, io_we_d;
    logic finish;

    // Bus cycle ends on the enabled edge of its final state
    assign finish = (st_q == pbwa_pkg::PBWA_ST_BUSY) && last_q &&
                    state_en;

    // Next-state and data path for the whole bus cycle
    always_comb begin
        st_d = st_q;
        rg_d = rg_q;
        cnt_d = cnt_q;
        len_d = len_q;
        we_d = we_q;
        word_d = word_q;
        addr_d = addr_q;
        wd_d = wd_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        mem_en_d = mem_en_q;
        io_en_d = io_en_q;
        last_d = last_q;
        be_d = be_q;
        io_wd_d = io_wd_q;
        unique case (st_q)
            pbwa_pkg::PBWA_ST_IDLE: begin
                if (req) begin
                    rg_d = decode(req_addr);
                    len_d = states_for(rg_d, req_addr);
                    st_d = pbwa_pkg::PBWA_ST_BUSY;
                    cnt_d = 2'h1;
                    last_d = 1'b0;
                    we_d = req_we;
                    word_d = req_word;
                    addr_d = req_addr;
                    // Byte data replicated so either lane can take it
                    wd_d = req_word ? req_wdata :
                                      {req_wdata[7:0], req_wdata[7:0]};
                    mem_en_d = (rg_d == pbwa_pkg::PBWA_RG_ROM) ||
                               (rg_d == pbwa_pkg::PBWA_RG_RAM);
                    io_en_d = (rg_d == pbwa_pkg::PBWA_RG_IO16) ||
                              (rg_d == pbwa_pkg::PBWA_RG_IO96);
                    // Whole word in one access on the wide path
                    if (req_word)
                        be_d = 2'h3;
                    else if (req_addr[0])
                        be_d = 2'h1;
                    else
                        be_d = 2'h2;
                    // Narrow path carries the high byte of a word
                    io_wd_d = req_word ? req_wdata[15:8] :
                                         req_wdata[7:0];
                end
            end
            pbwa_pkg::PBWA_ST_BUSY: begin
                if (finish) begin
                    st_d = pbwa_pkg::PBWA_ST_IDLE;
                    done_d = 1'b1;
                    mem_en_d = 1'b0;
                    io_en_d = 1'b0;
                    last_d = 1'b0;
                    if (we_q)
                        rdata_d = `PBWA_EMPTY_DATA;
                    else if (mem_en_q) begin
                        if (word_q)
                            rdata_d = mem_rdata;
                        else if (addr_q[0])
                            rdata_d = {8'h00, mem_rdata[7:0]};
                        else
                            rdata_d = {8'h00, mem_rdata[15:8]};
                    end else if (io_en_q) begin
                        // Low half on a word read carries no data
                        if (word_q)
                            rdata_d = {io_rdata,
                                       `PBWA_UNDEF_BYTE};
                        else
                            rdata_d = {8'h00, io_rdata};
                    end else
                        rdata_d = `PBWA_EMPTY_DATA;
                end else if (state_en) begin
                    cnt_d = cnt_q + 2'h1;
                    last_d = (cnt_d == len_q);
                end
            end
            default: st_d = pbwa_pkg::PBWA_ST_IDLE;
        endcase
        // Strobes registered so every output leaves a flip-flop
        busy_d = (st_d == pbwa_pkg::PBWA_ST_BUSY);
        mem_we_d = mem_en_d & we_d;
        // Only one byte strobe exists, so a low byte can never land
        io_we_d = io_en_d & we_d;
    end

    // Registers only; everything resets to an idle bus
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= pbwa_pkg::PBWA_ST_IDLE;
            rg_q <= pbwa_pkg::PBWA_RG_NONE;
            cnt_q <= 2'h0;
            len_q <= 2'h0;
            we_q <= 1'b0;
            word_q <= 1'b0;
            addr_q <= 16'h0000;
            wd_q <= 16'h0000;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
            mem_en_q <= 1'b0;
            io_en_q <= 1'b0;
            last_q <= 1'b0;
            be_q <= 2'h0;
            io_wd_q <= 8'h00;
            busy_q <= 1'b0;
            mem_we_q <= 1'b0;
            io_we_q <= 1'b0;
        end else begin
            st_q <= st_d;
            rg_q <= rg_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            we_q <= we_d;
            word_q <= word_d;
            addr_q <= addr_d;
            wd_q <= wd_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            mem_en_q <= mem_en_d;
            io_en_q <= io_en_d;
            last_q <= last_d;
            be_q <= be_d;
            io_wd_q <= io_wd_d;
            busy_q <= busy_d;
            mem_we_q <= mem_we_d;
            io_we_q <= io_we_d;
        end
    end

    // Outputs straight from flip-flops
    assign busy = busy_q;
    assign done = done_q;
    assign rdata = rdata_q;
    assign region = rg_q;
    assign mem_en = mem_en_q;
    assign mem_we = mem_we_q;
    assign mem_be = be_q;
    assign mem_addr = {addr_q[15:1], 1'b0};
    assign mem_wdata = wd_q;
    assign io_en = io_en_q;
    assign io_we = io_we_q;
    assign io_addr = addr_q;
    assign io_wdata = io_wd_q;
    assign last = last_q;
endmodule

// [design/pbwa_defines.svh]
// Purpose: Constants for the peripheral bus width adapter.
// Assumes: 16-bit byte address space, big-endian word lanes.
// Notes: ROM base sits at the bottom of the map; the other region bases sit near the top.
// Functional notes
// - Peripheral transfers use an eight-bit path only
// - I/O word write stores high byte
// - I/O word write drops low byte
// - I/O word read returns byte in upper half
// - I/O word read lower half is undefined
// - ROM and RAM take bytes, words, two states
// - I/O areas byte only; three or two/three
// - State is one enabled clock; two or three
// - Memory path sixteen bits, word in one access
`ifndef PBWA_DEFINES_SVH
`define PBWA_DEFINES_SVH
`define PBWA_ROM_BASE 16'h0000
`define PBWA_ROM_BYTES 17'h08000
`define PBWA_IO16_BASE 16'hF740
`define PBWA_IO16_BYTES 17'h00010
`define PBWA_RAM_BASE 16'hFB80
`define PBWA_RAM_BYTES 17'h00400
`define PBWA_IO96_BASE 16'hFFA0
`define PBWA_IO96_BYTES 17'h00060
`define PBWA_SLOW_LO 16'hFFA0
`define PBWA_SLOW_HI 16'hFFBF
`define PBWA_STATES_MEM 2'h2
`define PBWA_STATES_FAST 2'h2
`define PBWA_STATES_SLOW 2'h3
`define PBWA_UNDEF_BYTE 8'hFF
`define PBWA_EMPTY_DATA 16'h0000
`endif

// [design/pbwa_pkg.sv]
// Purpose: Types for the peripheral bus width adapter.
// Assumes: Used by pbwa_bridge only through scoped names.
// Notes: Holds no logic.
package pbwa_pkg;
    typedef enum logic [2:0] {
        PBWA_RG_ROM,
        PBWA_RG_RAM,
        PBWA_RG_IO16,
        PBWA_RG_IO96,
        PBWA_RG_NONE
    } pbwa_region_t;
    typedef enum logic {
        PBWA_ST_IDLE,
        PBWA_ST_BUSY
    } pbwa_state_t;
endpackage

// [tb/pbwa_bridge_asserts.sv]
// Purpose: Timing and lane checks on the ports of pbwa_bridge.
// Assumes: state_en held high, so each state is one clock.
// Notes: Word and direction of the taken request are kept in helpers.
`timescale 1ns/1ps
`include "pbwa_defines.svh"
module pbwa_bridge_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic req,
    input wire logic req_we,
    input wire logic req_word,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] rdata,
    input wire logic [2:0] region,
    input wire logic mem_en,
    input wire logic [1:0] mem_be,
    input wire logic io_en,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic last
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic take, a_io16, a_mem, w_q, we_q;
    // Address decode of the request being taken
    assign take = req && !busy;
    assign a_io16 = req_addr[15:4] == 12'hF74;
    assign a_mem = !req_addr[15] ||
                   (req_addr >= 16'hFB80 && req_addr <= 16'hFF7F);
    // Size and direction of the cycle in flight
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            {w_q, we_q} <= 2'h0;
        else if (take)
            {w_q, we_q} <= {req_word, req_we};
    end
    chk_take_busy: assert property (take |=> busy)
        else $error("busy not raised after take");
    chk_mem_two: assert property (take && a_mem |=>
        mem_en && !last ##1 last ##1 done && !mem_en)
        else $error("memory cycle not two states");
    chk_io16_three: assert property (take && a_io16 |=>
        io_en && !last ##1 !last ##1 last ##1 done)
        else $error("io16 cycle not three states");
    chk_io_wr_byte: assert property (
        take && a_io16 && req_we |=> io_wdata == ($past(req_word) ?
        $past(req_wdata[15:8]) : $past(req_wdata[7:0])))
        else $error("wrong byte on peripheral write");
    chk_rd_upper: assert property (
        done && w_q && !we_q && region == 3'h2 |->
        rdata[15:8] == $past(io_rdata))
        else $error("io word read upper half wrong");
    chk_word_lanes: assert property (mem_en && w_q |-> mem_be == 2'h3)
        else $error("word access not on both lanes");
    chk_narrow_path: assert property (io_en |-> !mem_en)
        else $error("peripheral cycle drove memory path");
    chk_done_pulse: assert property (done |-> !busy ##1 !done)
        else $error("done not a single pulse");
    cov_mem: cover property (take && a_mem);
    cov_io16_word: cover property (take && a_io16 && req_word);
    cov_io96: cover property (take && req_addr >= `PBWA_IO96_BASE);
endmodule
bind pbwa_bridge pbwa_bridge_asserts pbwa_bridge_asserts_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .req_we(req_we),
    .req_word(req_word), .req_addr(req_addr), .req_wdata(req_wdata),
    .busy(busy), .done(done), .rdata(rdata), .region(region),
    .mem_en(mem_en), .mem_be(mem_be), .io_en(io_en), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .last(last));

// [tb/pbwa_far_model.sv]
// Purpose: Far-side memory and peripheral register model for pbwa_bridge.
// Assumes: Writes commit at the edge where last and state_en are high.
// Notes: Idle buses show inverted data, so a stale value never passes.
`timescale 1ns/1ps
module pbwa_far_model (
    input wire logic clk_sys,
    input wire logic state_en,
    input wire logic last,
    input wire logic mem_en,
    input wire logic mem_we,
    input wire logic [1:0] mem_be,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    input wire logic io_en,
    input wire logic io_we,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata
);
    logic [15:0] mem [16];
    logic [7:0] io [16];
    // Known contents so every read has a figure to match
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'h0000;
            io[i] = 8'h5A;
        end
    end
    // Lane-enabled word store and byte-only register store
    always @(posedge clk_sys) begin
        if (mem_en && mem_we && last && state_en && mem_be[1])
            mem[mem_addr[4:1]][15:8] <= mem_wdata[15:8];
        if (mem_en && mem_we && last && state_en && mem_be[0])
            mem[mem_addr[4:1]][7:0] <= mem_wdata[7:0];
        if (io_en && io_we && last && state_en)
            io[io_addr[3:0]] <= io_wdata;
    end
    // Unselected buses flip their data instead of holding it
    assign mem_rdata = mem_en ? mem[mem_addr[4:1]] : ~mem[mem_addr[4:1]];
    assign io_rdata = io_en ? io[io_addr[3:0]] : ~io[io_addr[3:0]];
endmodule

// [tb/peripheral_bus_width_adapter_tb.sv]
// Purpose: Self-checking bench for pbwa_bridge with a far-side model.
// Assumes: System clock only; state_en tied high.
// Notes: Each access is timed from its taking edge to done.
`timescale 1ns/1ps
module peripheral_bus_width_adapter_tb;
    logic clk_sys, rst_n, state_en, req, req_we, req_word, busy, done;
    logic mem_en, mem_we, io_en, io_we, last;
    logic [15:0] req_addr, req_wdata, rdata, mem_addr, mem_wdata, mem_rdata;
    logic [15:0] io_addr, r;
    logic [7:0] io_wdata, io_rdata;
    logic [2:0] region;
    logic [1:0] mem_be;
    int fail_count, n_checks, cycles;
    pbwa_bridge pbwa_bridge_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .state_en(state_en), .req(req), .req_we(req_we), .req_word(req_word),
        .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done),
        .rdata(rdata), .region(region), .mem_en(mem_en), .mem_we(mem_we),
        .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .io_en(io_en), .io_we(io_we), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .last(last));
    pbwa_far_model pbwa_far_model_inst (.clk_sys(clk_sys), .state_en(state_en),
        .last(last), .mem_en(mem_en), .mem_we(mem_we), .mem_be(mem_be),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .io_en(io_en), .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata));
    // Clock and hang guard; a run past the ceiling counts as a mismatch
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    // One whole bus cycle; states counted on falling edges until done
    task automatic access(input logic we, input logic word,
        input logic [15:0] addr, input logic [15:0] wd, input int states,
        output logic [15:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        req <= 1'b1;
        req_we <= we;
        req_word <= word;
        req_addr <= addr;
        req_wdata <= wd;
        @(posedge clk_sys);
        req <= 1'b0;
        while (done !== 1'b1 && n < 10) begin
            @(negedge clk_sys);
            n++;
        end
        check(16'(n), 16'(states + 1), "state count");
        rd = rdata;
    endtask
    task automatic t_mem();
        access(1'b1, 1'b1, 16'hFB80, 16'h1234, 2, r);
        access(1'b0, 1'b1, 16'hFB80, 16'h0000, 2, r);
        check(r, 16'h1234, "ram word read");
        access(1'b0, 1'b0, 16'hFB81, 16'h0000, 2, r);
        check(r, 16'h0034, "ram odd byte read");
        access(1'b0, 1'b1, 16'h0002, 16'h0000, 2, r);
        check(r, 16'h0000, "rom word read");
        check(16'(region), 16'h0000, "rom region");
        access(1'b1, 1'b0, 16'hFB83, 16'h00CD, 2, r);
        access(1'b0, 1'b1, 16'hFB82, 16'h0000, 2, r);
        check(r, 16'h00CD, "ram odd byte write lane");
        check(16'(region), 16'h0001, "ram region");
        $display("t_mem done");
    endtask
    task automatic t_io_word();
        access(1'b1, 1'b1, 16'hF740, 16'hA53C, 3, r);
        access(1'b0, 1'b0, 16'hF740, 16'h0000, 3, r);
        check(r, 16'h00A5, "io word write high byte");
        access(1'b0, 1'b0, 16'hF741, 16'h0000, 3, r);
        check(r, 16'h005A, "io word write low byte kept out");
        access(1'b0, 1'b1, 16'hF740, 16'h0000, 3, r);
        check(r, 16'hA5FF, "io word read lanes");
        check(16'(region), 16'h0002, "io16 region");
        $display("t_io_word done");
    endtask
    task automatic t_io96();
        access(1'b1, 1'b0, 16'hFFA5, 16'h00C3, 3, r);
        access(1'b0, 1'b0, 16'hFFA5, 16'h0000, 3, r);
        check(r, 16'h00C3, "io96 slow byte read");
        access(1'b0, 1'b0, 16'hFFC6, 16'h0000, 2, r);
        check(r, 16'h005A, "io96 fast byte read");
        check(16'(region), 16'h0003, "io96 region");
        access(1'b0, 1'b1, 16'h9000, 16'h0000, 2, r);
        check(r, 16'h0000, "empty area read");
        check(16'(region), 16'h0004, "empty region");
        $display("t_io96 done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Reset for five cycles, then the scenarios back to back
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        state_en = 1'b1;
        req = 1'b0;
        req_we = 1'b0;
        req_word = 1'b0;
        req_addr = 16'h0000;
        req_wdata = 16'h0000;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_mem();
        t_io_word();
        t_io96();
        stop_test();
    end
endmodule
